// ==== src/ubg_defs.svh ====
`ifndef UBG_DEFS_SVH
`define UBG_DEFS_SVH
`define UBG_ADDR_MODE      12'h000
`define UBG_ADDR_STATUS    12'h004
`define UBG_ADDR_DIVISOR   12'h008
`define UBG_ADDR_IRQ_STAT  12'h00C
`define UBG_ADDR_IRQ_MASK  12'h010
`define UBG_MODE_EN_BIT    15
`define UBG_MODE_PIN_LO    8
`define UBG_MODE_HS_BIT    3
`define UBG_MODE_WMASK     16'h8308
`define UBG_STA_TXBF_BIT   9
`define UBG_STA_TXEMPTY_BIT 8
`define UBG_IRQ_TICK_BIT   0
`define UBG_IRQ_TXBF_BIT   1
`define UBG_IRQ_WMASK      16'h0003
`define UBG_DIV_RESET      16'h0000
`define UBG_OVS_LO         5'h10
`define UBG_OVS_HI         5'h04
`endif

// ==== src/ubg_pkg.sv ====
package ubg_pkg;
  typedef struct packed {
    logic        en;
    logic [1:0]  pin_usage;
    logic        high_speed;
  } ubg_cfg_s;
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } ubg_gen_s;
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] divisor;
    logic [15:0] irq_stat;
    logic [15:0] irq_mask;
    logic [4:0]  tick_cnt;
    logic        bit_tick;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        port_en;
    logic [1:0]  pin_sel;
    logic        txbf;
    logic        txbf_prev;
    logic        div_wr;
  } ubg_state_s;
endpackage

// ==== src/ubg_counter.sv ====
`timescale 1ns/1ps
`include "ubg_defs.svh"
module ubg_counter
  import ubg_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] divisor,
  input  wire logic             restart,
  output logic                  tick
);
  ubg_gen_s s_q;
  ubg_gen_s s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= divisor) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule

// ==== src/ubg_top.sv ====
// Operation
// - baud generator is a free-running 16-bit counter, period set by divisor
// - normal speed: bit rate is clock over 16 times divisor plus one
// - high speed: bit rate is clock over 4 times divisor plus one
// - a divisor write clears the generator counter one clock after the divisor register takes the new value
// - status bit 9 reads one while transmit buffer cannot take a character
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ubg_defs.svh"
module ubg_top
  import ubg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_buffer_full,
  input  wire logic        tx_shift_empty,
  output logic             baud_tick,
  output logic             bit_tick,
  output logic             high_speed_baud_select,
  output logic             serial_module_enable,
  output logic [1:0]       pin_usage_field,
  output logic             irq
);
  ubg_state_s s_q;
  ubg_state_s s_d;
  logic       gen_tick;
  logic       wr_acc;
  logic       rd_acc;
  logic       hit;
  logic [15:0] wdata16;
  logic [15:0] stat_word;
  logic [15:0] ev;

  ubg_counter #(
    .WIDTH (16)
  ) u_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .divisor (s_q.divisor),
    .restart (s_q.div_wr),
    .tick    (gen_tick)
  );

  always_comb begin
    hit = (paddr == `UBG_ADDR_MODE) || (paddr == `UBG_ADDR_STATUS) ||
          (paddr == `UBG_ADDR_DIVISOR) || (paddr == `UBG_ADDR_IRQ_STAT) ||
          (paddr == `UBG_ADDR_IRQ_MASK);
    wr_acc = psel && penable && pwrite && !s_q.pready && hit;
    rd_acc = psel && penable && !pwrite && !s_q.pready;
    wdata16 = pwdata[15:0];
    stat_word = '0;
    stat_word[`UBG_STA_TXBF_BIT]    = s_q.txbf;
    stat_word[`UBG_STA_TXEMPTY_BIT] = tx_shift_empty && !s_q.txbf;
    ev = '0;
    ev[`UBG_IRQ_TICK_BIT] = s_q.bit_tick;
    ev[`UBG_IRQ_TXBF_BIT] = s_q.txbf && !s_q.txbf_prev;
  end

  always_comb begin
    s_d = s_q;
    s_d.pready   = 1'b0;
    s_d.pslverr  = 1'b0;
    s_d.div_wr   = 1'b0;
    s_d.bit_tick = 1'b0;
    s_d.txbf      = tx_buffer_full;
    s_d.txbf_prev = s_q.txbf;
    if (psel && penable && !s_q.pready) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !hit;
    end
    if (wr_acc && pstrb[1:0] == 2'h3) begin
      unique case (paddr)
        `UBG_ADDR_MODE: begin
          s_d.mode = wdata16 & `UBG_MODE_WMASK;
        end
        `UBG_ADDR_DIVISOR: begin
          s_d.divisor = wdata16;
          s_d.div_wr  = 1'b1;
        end
        `UBG_ADDR_IRQ_MASK: begin
          s_d.irq_mask = wdata16 & `UBG_IRQ_WMASK;
        end
        default: begin
        end
      endcase
    end
    // write one to clear; new events win over the clear
    if (wr_acc && pstrb[1:0] == 2'h3 && paddr == `UBG_ADDR_IRQ_STAT) begin
      s_d.irq_stat = s_q.irq_stat & ~wdata16;
    end
    s_d.irq_stat = (s_d.irq_stat | ev) & `UBG_IRQ_WMASK;
    if (s_q.div_wr) begin
      s_d.tick_cnt = '0;
    end else if (gen_tick) begin
      if (s_q.tick_cnt + 5'h01 >= (s_q.mode[`UBG_MODE_HS_BIT] ? `UBG_OVS_HI : `UBG_OVS_LO))
      begin
        s_d.tick_cnt = '0;
        s_d.bit_tick = 1'b1;
      end else begin
        s_d.tick_cnt = s_q.tick_cnt + 5'h01;
      end
    end
    if (rd_acc) begin
      s_d.prdata = '0;
      unique case (paddr)
        `UBG_ADDR_MODE:     s_d.prdata[15:0] = s_q.mode;
        `UBG_ADDR_STATUS:   s_d.prdata[15:0] = stat_word;
        `UBG_ADDR_DIVISOR:  s_d.prdata[15:0] = s_q.divisor;
        `UBG_ADDR_IRQ_STAT: s_d.prdata[15:0] = s_q.irq_stat;
        `UBG_ADDR_IRQ_MASK: s_d.prdata[15:0] = s_q.irq_mask;
        default:            s_d.prdata       = '0;
      endcase
    end
    s_d.port_en = s_q.mode[`UBG_MODE_EN_BIT];
    s_d.pin_sel = s_q.mode[`UBG_MODE_PIN_LO+1:`UBG_MODE_PIN_LO];
    s_d.irq     = |(s_q.irq_stat & s_q.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_tick              <= 1'b0;
      high_speed_baud_select <= 1'b0;
    end else begin
      baud_tick              <= gen_tick;
      high_speed_baud_select <= s_q.mode[`UBG_MODE_HS_BIT];
    end
  end

  assign prdata               = s_q.prdata;
  assign pready               = s_q.pready;
  assign pslverr              = s_q.pslverr;
  assign bit_tick             = s_q.bit_tick;
  assign serial_module_enable = s_q.port_en;
  assign pin_usage_field      = s_q.pin_sel;
  assign irq                  = s_q.irq;
endmodule

// ==== verification/ubg_sva.sv ====
`timescale 1ns/1ps
module ubg_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        tx_buffer_full,
  input wire logic        baud_tick,
  input wire logic        bit_tick,
  input wire logic        high_speed_baud_select,
  input wire logic        serial_module_enable,
  input wire logic [1:0]  pin_usage_field
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr  = psel && penable && pready && pwrite;
  wire mwr = wr && paddr == 12'h000;
  sequence s_gap_lo; (!bit_tick || high_speed_baud_select)[*8]; endsequence
  sequence s_gap_hi; (!bit_tick || !high_speed_baud_select)[*3]; endsequence
  sequence s_status_read;
    psel && penable && pready && !pwrite && paddr == 12'h004;
  endsequence
  a_bit_normal: assert property (bit_tick && !high_speed_baud_select |=> s_gap_lo)
    else $error("bit ticks too close at normal speed");
  a_bit_fast: assert property (bit_tick && high_speed_baud_select |=> s_gap_hi)
    else $error("bit ticks too close at high speed");
  a_div_restart: assert property (wr && paddr == 12'h008 && pwdata[15:0] == 16'h0000
    |-> ##[1:4] baud_tick) else $error("no baud tick after divisor write");
  a_mode_copy: assert property (!$stable({serial_module_enable, pin_usage_field,
    high_speed_baud_select}) |-> $past(mwr) || $past(mwr, 2))
    else $error("mode outputs moved without a mode write");
  // status word is captured from the flag as it stood two edges before pready
  a_full_flag: assert property (s_status_read |-> prdata[9] == $past(tx_buffer_full, 2))
    else $error("full flag read back wrong");
  a_bit_on_baud: assert property (bit_tick |-> baud_tick || $past(baud_tick))
    else $error("bit tick without baud tick");
endmodule
bind ubg_top ubg_sva i_ubg_sva (.*);

// ==== verification/ubg_partner.sv ====
`timescale 1ns/1ps
module ubg_partner (
  input  wire logic pclk,
  input  wire logic full_cmd,
  output logic      tx_buffer_full = 1'b0,
  output logic      tx_shift_empty = 1'b1
);
  // far-side buffer: shifter idles only while nothing waits
  always @(posedge pclk) begin
    tx_buffer_full <= full_cmd;
    tx_shift_empty <= !full_cmd;
  end
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, full = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, txf, txe, baud_tick, bit_tick, hs, en, irq;
  logic [1:0]  pins;
  int          mismatches = 0, num_checks = 0, n;
  always #5 pclk = ~pclk;
  ubg_partner i_ubg_partner (.pclk(pclk), .full_cmd(full), .tx_buffer_full(txf),
    .tx_shift_empty(txe));
  ubg_top i_ubg_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_buffer_full(txf), .tx_shift_empty(txe),
    .baud_tick(baud_tick), .bit_tick(bit_tick), .high_speed_baud_select(hs),
    .serial_module_enable(en), .pin_usage_field(pins), .irq(irq));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic gap(ref logic s, output int c);
    c = 0;
    do begin @(posedge pclk); c++; end while (s !== 1'b1);
  endtask
  task automatic t_regs;
    apb(0, 12'h008, 0); chk("divisor", rd, 0);
    apb(1, 12'h000, 32'hFFFF); apb(0, 12'h000, 0); chk("mode", rd, 32'h8308);
    chk("outputs", {en, pins, hs}, 4'hF);
    apb(0, 12'h014, 0); chk("slverr", err, 1);
  endtask
  task automatic t_rate;
    for (int h = 0; h < 2; h++) begin
      apb(1, 12'h000, h << 3); apb(1, 12'h008, 2);
      gap(baud_tick, n); gap(baud_tick, n); chk("baud gap", n, 3);
      gap(bit_tick, n); gap(bit_tick, n); chk("bit gap", n, h ? 12 : 48);
    end
  endtask
  task automatic t_restart;
    apb(1, 12'h008, 9); gap(baud_tick, n);
    apb(1, 12'h008, 9); gap(baud_tick, n);
    chk("restart", n, 11);
    apb(1, 12'h008, 0); gap(baud_tick, n);
    chk("restart zero", n, 2);
  endtask
  task automatic t_full;
    apb(1, 12'h010, 2); full <= 1; repeat (4) @(posedge pclk);
    apb(0, 12'h004, 0); chk("full", rd[9], 1); chk("irq", irq, 1);
    chk("shift empty full", rd[8], 0);
    apb(1, 12'h00C, 3); @(posedge pclk); chk("irq clr", irq, 0);
    full <= 0; repeat (4) @(posedge pclk);
    apb(0, 12'h004, 0); chk("not full", rd[9], 0);
    chk("shift empty idle", rd[8], 1);
  endtask
  task automatic results;
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs; t_rate; t_restart; t_full;
    results;
  end
  initial begin
    #100000;
    mismatches++;
    results;
  end
endmodule
